/* File: design/dbe_map.svh */
// Register offsets, bit positions, reset values and check limits
// Included by the package and the event status design file; definitions only
`ifndef DBE_MAP_SVH
`define DBE_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DBE_OFS_EVENT_STATUS 10'h026
`define DBE_OFS_CHECK_FLAGS  10'h030
`define DBE_OFS_SYNC_CONTROL 10'h03A

// ----------------------------------------------------------------
// Event status bit positions
// ----------------------------------------------------------------
`define DBE_BIT_TRIP         0
`define DBE_BIT_WINDOW       1
`define DBE_BIT_ROTATE       2
`define DBE_BIT_LOCK         3
`define DBE_BIT_OSC_ALIGN    4
`define DBE_BIT_BLANK        5
`define DBE_BIT_RESERVED     6
`define DBE_BIT_POWER        7

// ----------------------------------------------------------------
// Check flag bit positions
// ----------------------------------------------------------------
`define DBE_CHK_INTERP       0
`define DBE_CHK_SUBCLASS     1
`define DBE_CHK_K            2
`define DBE_CHK_COMBO        3
`define DBE_CHK_WINDOW       4
`define DBE_CHK_DELAY        5

// Sticky-clear bit in the sync control register
`define DBE_CTL_STICKY_CLR   5

// ----------------------------------------------------------------
// Reset values and check limits
// ----------------------------------------------------------------
`define DBE_RST_STATUS       8'h00
`define DBE_RST_CHECKS       8'h00
`define DBE_RST_CONTROL      8'h00
`define DBE_K_SMALL          8'h10
`define DBE_K_LARGE          8'h20
`define DBE_WIN_LIMIT_MAX    3'h3
`define DBE_OCTETS_PER_SMP   8'h02

`endif

/* File: design/dbe_pkg.sv */
// Types shared by the event-status block and its testbench
// Assumes dbe_map.svh is on the include path
package dbe_pkg;
  `include "dbe_map.svh"

  // Link configuration as presented by the configuration registers
  typedef struct packed {
    logic [7:0] k_frames;     // Frames per multiframe
    logic [7:0] lmfc_delay;   // Multiframe clock delay in frames
    logic [2:0] subclass;     // Link subclass
    logic [3:0] interp;       // Interpolation factor
    logic [2:0] win_limit;    // Sysref window limit
    logic [3:0] conv_m;       // Converters
    logic [3:0] lanes_l;      // Lanes
    logic [3:0] smp_s;        // Samples per frame per converter
    logic [3:0] oct_f;        // Octets per frame
  } dbe_cfg_type;

  // Register port request
  typedef struct packed {
    logic       wr;           // Write strobe, one cycle
    logic       rd;           // Read strobe, one cycle
    logic [9:0] addr;         // Register offset
    logic [7:0] wdata;        // Write data
  } dbe_req_type;
endpackage

/* File: design/dbe_event_cell.sv */
// One event status bit: follow or rising-edge latch with clear
// Assumes live_i and clears come from logic on clock_i
`timescale 1ns/1ps
module dbe_event_cell (
  input  wire logic clock_i,     // Block clock
  input  wire logic rst_n_i,     // Synchronised reset, active low
  input  wire logic latch_sel_i, // High selects latching mode
  input  wire logic live_i,      // Live event condition
  input  wire logic clear_i,     // Clear request, one cycle
  output logic      state_o      // Status bit as read back
);
  logic live_q;                  // Previous live level for edge detect

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live_q <= 1'b0;
    end else begin
      live_q <= live_i;
    end
  end

  // ----------------------------------------------------------------
  // Status bit update
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_o <= 1'b0;
    end else if (!latch_sel_i) begin
      // (RULE_07) Follow mode copies live
      state_o <= live_i;
    end else if (live_i && !live_q) begin
      // (RULE_08) Rising edge sets, wins over clear
      state_o <= 1'b1;
    end else if (clear_i) begin
      // (RULE_09) Clear request drops bit
      state_o <= 1'b0;
    end
  end
endmodule

/* File: design/dbe_event_status.sv */
// Dual B event status register and link configuration checker
// Assumes event sources and configuration run on clock_i
//
// Behaviour
// (RULE_01) Bit 5 reports blanking done
// (RULE_02) Bit 4 reports oscillator align trip
// (RULE_03) Bit 3 reports frame clock lock
// (RULE_04) Bit 2 reports frame clock rotated
// (RULE_05) Bit 1 reports phase outside window
// (RULE_06) Bit 0 reports frame clock tripped
// (RULE_07) Select low: bit follows live condition
// (RULE_08) Select high: latch on rise, interrupt low
// (RULE_09) Write one clears latched bit
// (RULE_10) Check bit 5: delay exceeds K
// (RULE_11) Check bit 4: unsupported window limit
// (RULE_12) Check bit 3: unsupported link combination
// (RULE_13) Check bit 2: K not 16/32
// (RULE_14) Check bit 1: subclass not 0/1
// (RULE_15) Check bit 0: interpolation not 1/2/4/8
// (RULE_16) Flags reset zero, read-only, 7:6 reserved
// (RULE_17) Status at 0x026, bit 7 power detect
// (RULE_18) Sticky-clear rise clears rotate and trip
// (RULE_19) Interrupt low while latched bit set
// (RULE_20) Checks evaluated every cycle, no latching
`timescale 1ns/1ps
`include "dbe_map.svh"
module dbe_event_status
  import dbe_pkg::*;
(
  input  wire logic        clock_i,        // 200 MHz block clock
  input  wire logic        arst_n_i,       // Asynchronous reset, active low
  input  wire dbe_req_type req_i,          // Register port request
  input  wire dbe_cfg_type cfg_i,          // Link configuration
  input  wire logic [7:0]  event_live_i,   // Live conditions by status bit
  input  wire logic [7:0]  latch_sel_i,    // Latching mode select by bit
  output logic [7:0]       rd_data_o,      // Read data, one cycle after rd
  output logic [7:0]       status_o,       // Event status register
  output logic [7:0]       check_flags_o,  // Configuration check flags
  output logic             irq_n_o         // Interrupt, active low
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic       rst_meta_q;                  // First reset stage
  logic       rst_n_q;                     // Synchronised reset

  // Two-stage release, assertion stays asynchronous
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic       wr_status;                   // Write hits status register
  logic       wr_control;                  // Write hits sync control
  logic [7:0] control_q;                   // Sync control register
  logic       sticky_clr_q;                // Previous sticky-clear level
  logic       sticky_rise;                 // Sticky-clear rising edge
  logic [7:0] clear_vec;                   // Per-bit clear requests
  logic [7:0] status_vec;                  // Cell outputs

  assign wr_status  = req_i.wr && (req_i.addr == `DBE_OFS_EVENT_STATUS);
  assign wr_control = req_i.wr && (req_i.addr == `DBE_OFS_SYNC_CONTROL);

  // Sync control register, all bits writable
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      control_q <= `DBE_RST_CONTROL;
    end else if (wr_control) begin
      control_q <= req_i.wdata;
    end
  end

  // Edge history of the sticky-clear bit
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sticky_clr_q <= 1'b0;
    end else begin
      sticky_clr_q <= control_q[`DBE_CTL_STICKY_CLR];
    end
  end

  // (RULE_18) Sticky clear edge
  assign sticky_rise = control_q[`DBE_CTL_STICKY_CLR] && !sticky_clr_q;

  // Clear vector: write-one per bit, plus sticky clear on rotate and trip
  always_comb begin
    // (RULE_09) Write one clears
    clear_vec = wr_status ? req_i.wdata : 8'h00;
    // (RULE_18) Rotate and trip cleared
    clear_vec[`DBE_BIT_ROTATE] = clear_vec[`DBE_BIT_ROTATE] | sticky_rise;
    clear_vec[`DBE_BIT_TRIP]   = clear_vec[`DBE_BIT_TRIP] | sticky_rise;
  end

  // ----------------------------------------------------------------
  // Event status cells
  // ----------------------------------------------------------------
  // (RULE_01) Bit 5 blanking cell
  // (RULE_02) Bit 4 oscillator cell
  // (RULE_03) Bit 3 lock cell
  // (RULE_04) Bit 2 rotate cell
  // (RULE_05) Bit 1 window cell
  // (RULE_06) Bit 0 trip cell
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cell
      if (gi == `DBE_BIT_RESERVED) begin : g_rsvd
        // Reserved bit reads zero
        assign status_vec[gi] = 1'b0;
      end else begin : g_evt
        // (RULE_07) Follow or latch per bit
        dbe_event_cell u_cell (
          .clock_i     (clock_i),
          .rst_n_i     (rst_n_q),
          .latch_sel_i (latch_sel_i[gi]),
          .live_i      (event_live_i[gi]),
          .clear_i     (clear_vec[gi]),
          .state_o     (status_vec[gi])
        );
      end
    end
  endgenerate

  // (RULE_17) Status register image
  assign status_o = status_vec;

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // (RULE_19) Low while latched bit
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= ~|(status_vec & latch_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // Configuration checks
  // ----------------------------------------------------------------
  logic [7:0] check_d;                     // Next check flag image
  logic [7:0] lane_octets;                 // Octets carried per frame
  logic [7:0] conv_octets;                 // Octets needed per frame

  always_comb begin
    check_d     = `DBE_RST_CHECKS;
    lane_octets = 8'({4'h0, cfg_i.lanes_l} * {4'h0, cfg_i.oct_f});
    conv_octets = 8'({4'h0, cfg_i.conv_m} * {4'h0, cfg_i.smp_s} * `DBE_OCTETS_PER_SMP);
    // (RULE_10) Delay beyond K
    check_d[`DBE_CHK_DELAY] = cfg_i.lmfc_delay > cfg_i.k_frames;
    // (RULE_11) Window limit range
    check_d[`DBE_CHK_WINDOW] = cfg_i.win_limit > `DBE_WIN_LIMIT_MAX;
    // (RULE_12) Link combination check
    case (cfg_i.lanes_l)
      4'h1, 4'h2, 4'h4, 4'h8: begin
        check_d[`DBE_CHK_COMBO] = (conv_octets != lane_octets) || (cfg_i.conv_m == 4'h0)
                                  || (cfg_i.conv_m > 4'h4) || (cfg_i.smp_s == 4'h0);
      end
      default: begin
        check_d[`DBE_CHK_COMBO] = 1'b1;
      end
    endcase
    // (RULE_13) K must be 16 or 32
    check_d[`DBE_CHK_K] = (cfg_i.k_frames != `DBE_K_SMALL) && (cfg_i.k_frames != `DBE_K_LARGE);
    // (RULE_14) Subclass 0 or 1
    check_d[`DBE_CHK_SUBCLASS] = cfg_i.subclass > 3'h1;
    // (RULE_15) Interpolation 1, 2, 4, 8
    case (cfg_i.interp)
      4'h1, 4'h2, 4'h4, 4'h8: begin
        check_d[`DBE_CHK_INTERP] = 1'b0;
      end
      default: begin
        check_d[`DBE_CHK_INTERP] = 1'b1;
      end
    endcase
  end

  // (RULE_20) Refreshed every cycle
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      check_flags_o <= `DBE_RST_CHECKS;
    end else begin
      // (RULE_16) Reserved bits stay zero
      check_flags_o <= check_d;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Registered read mux, unmapped offsets read zero
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_data_o <= 8'h00;
    end else if (req_i.rd) begin
      case (req_i.addr)
        `DBE_OFS_EVENT_STATUS: begin
          rd_data_o <= status_vec;
        end
        `DBE_OFS_CHECK_FLAGS: begin
          rd_data_o <= check_flags_o;
        end
        `DBE_OFS_SYNC_CONTROL: begin
          rd_data_o <= control_q;
        end
        default: begin
          rd_data_o <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_q);

  // Follow mode: bit equals the live level one cycle back
  property p_follow(int b);
    rst_n_q && !latch_sel_i[b] |=> status_o[b] == $past(event_live_i[b]);
  endproperty

  a_blank_follow: assert property (p_follow(`DBE_BIT_BLANK)) // RULE_01
    else $error("Blank bit does not follow live");
  a_osc_follow: assert property (p_follow(`DBE_BIT_OSC_ALIGN)) // RULE_02
    else $error("Osc align bit does not follow live");
  a_lock_follow: assert property (p_follow(`DBE_BIT_LOCK)) // RULE_03
    else $error("Lock bit does not follow live");
  a_rotate_follow: assert property (p_follow(`DBE_BIT_ROTATE)) // RULE_04
    else $error("Rotate bit does not follow live");
  a_window_follow: assert property (p_follow(`DBE_BIT_WINDOW)) // RULE_05
    else $error("Window bit does not follow live");
  a_trip_follow: assert property (p_follow(`DBE_BIT_TRIP)) // RULE_06
    else $error("Trip bit does not follow live");

  a_latch_rise_irq: assert property ( // RULE_08
    rst_n_q && latch_sel_i[`DBE_BIT_LOCK] && $rose(event_live_i[`DBE_BIT_LOCK])
      && $stable(latch_sel_i) |=> status_o[`DBE_BIT_LOCK] ##1 !irq_n_o)
    else $error("Latched lock bit or interrupt missing");

  a_w1c_clear: assert property ( // RULE_09
    latch_sel_i[`DBE_BIT_BLANK] && wr_status && req_i.wdata[`DBE_BIT_BLANK]
      && !(event_live_i[`DBE_BIT_BLANK] && !$past(event_live_i[`DBE_BIT_BLANK]))
      |=> !status_o[`DBE_BIT_BLANK])
    else $error("Write one did not clear blank bit");

  a_k_check: assert property ( // RULE_13
    rst_n_q |=> check_flags_o[`DBE_CHK_K] == (($past(cfg_i.k_frames) != 8'h10)
      && ($past(cfg_i.k_frames) != 8'h20)))
    else $error("K check flag wrong");

  a_subclass_check: assert property ( // RULE_14
    cfg_i.subclass inside {3'h0, 3'h1} |=> !check_flags_o[`DBE_CHK_SUBCLASS])
    else $error("Subclass flag set for valid value");

  a_reserved_zero: assert property ( // RULE_16
    check_flags_o[7:6] == 2'b00 && status_o[`DBE_BIT_RESERVED] == 1'b0)
    else $error("Reserved bits nonzero");

  a_irq_level: assert property ( // RULE_19
    |(status_o & latch_sel_i) && $stable(latch_sel_i) |=> !irq_n_o)
    else $error("Interrupt not low with latched bit");

  // Power detect bit, same scheme as the event bits
  a_power_follow: assert property (p_follow(`DBE_BIT_POWER)) // RULE_17
    else $error("Power detect bit does not follow live");

  a_power_latch: assert property ( // RULE_17
    rst_n_q && latch_sel_i[`DBE_BIT_POWER] && $rose(event_live_i[`DBE_BIT_POWER])
      |=> status_o[`DBE_BIT_POWER])
    else $error("Power detect bit not latched on rise");

  a_zero_keeps: assert property ( // RULE_09
    latch_sel_i[`DBE_BIT_POWER] && status_o[`DBE_BIT_POWER]
      && !(wr_status && req_i.wdata[`DBE_BIT_POWER]) |=> status_o[`DBE_BIT_POWER])
    else $error("Latched power bit lost without a write of one");

  // Sticky clear acts on rotate and trip only
  a_sticky_clear: assert property ( // RULE_18
    sticky_rise && latch_sel_i[`DBE_BIT_ROTATE] && latch_sel_i[`DBE_BIT_TRIP]
      && !$rose(event_live_i[`DBE_BIT_ROTATE]) && !$rose(event_live_i[`DBE_BIT_TRIP])
      |=> !status_o[`DBE_BIT_ROTATE] && !status_o[`DBE_BIT_TRIP])
    else $error("Sticky clear left rotate or trip set");

  a_sticky_keep: assert property ( // RULE_18
    sticky_rise && latch_sel_i[`DBE_BIT_LOCK] && status_o[`DBE_BIT_LOCK] && !wr_status
      |=> status_o[`DBE_BIT_LOCK])
    else $error("Sticky clear dropped the lock bit");

  // Check flags against the configuration of the cycle before
  a_delay_check: assert property ( // RULE_10
    rst_n_q |=> check_flags_o[`DBE_CHK_DELAY]
      == ($past(cfg_i.lmfc_delay) > $past(cfg_i.k_frames)))
    else $error("Delay check flag wrong");

  a_window_check: assert property ( // RULE_11
    rst_n_q |=> check_flags_o[`DBE_CHK_WINDOW] == ($past(cfg_i.win_limit) > 3'h3))
    else $error("Window limit flag wrong");

  a_lane_check: assert property ( // RULE_12
    rst_n_q && (!(cfg_i.lanes_l inside {4'h1, 4'h2, 4'h4, 4'h8}) || cfg_i.conv_m == 4'h0)
      |=> check_flags_o[`DBE_CHK_COMBO])
    else $error("Unsupported lane or converter count not flagged");

  a_interp_check: assert property ( // RULE_15
    rst_n_q |=> check_flags_o[`DBE_CHK_INTERP]
      == !($past(cfg_i.interp) inside {4'h1, 4'h2, 4'h4, 4'h8}))
    else $error("Interpolation flag wrong");

  a_subclass_bad: assert property ( // RULE_14
    rst_n_q && cfg_i.subclass > 3'h1 |=> check_flags_o[`DBE_CHK_SUBCLASS])
    else $error("Unsupported subclass not flagged");

  a_irq_idle: assert property ( // RULE_19
    !(|(status_o & latch_sel_i)) |=> irq_n_o)
    else $error("Interrupt low with nothing latched");

  // Read port returns the register image of the request cycle
  a_read_status: assert property ( // RULE_17
    rst_n_q && req_i.rd && req_i.addr == `DBE_OFS_EVENT_STATUS
      |=> rd_data_o == $past(status_o))
    else $error("Status read data wrong");

  a_read_checks: assert property ( // RULE_16
    rst_n_q && req_i.rd && req_i.addr == `DBE_OFS_CHECK_FLAGS
      |=> rd_data_o == $past(check_flags_o))
    else $error("Check flag read data wrong");

  // Main scenarios reached
  c_latch_set: cover property (latch_sel_i[`DBE_BIT_TRIP] ##1 status_o[`DBE_BIT_TRIP]);
  c_irq_cycle: cover property (!irq_n_o ##1 wr_status ##[1:4] irq_n_o);
  c_sticky_clr: cover property (sticky_rise && status_o[`DBE_BIT_ROTATE]);
  c_bad_combo: cover property (check_flags_o[`DBE_CHK_COMBO]);
  c_power_latch: cover property (latch_sel_i[`DBE_BIT_POWER] ##1 status_o[`DBE_BIT_POWER]);

endmodule

/* File: verif/dbe_event_status_bench.sv */
// Self-checking testbench for the Dual B event status block
// Assumes dbe_pkg and dbe_map.svh compiled first; one 200 MHz clock
`timescale 1ns/1ps
module dbe_event_status_bench;
  import dbe_pkg::*;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic        clock_i;       // Block clock
  logic        arst_n_i;      // Reset, active low
  dbe_req_type req_i;         // Register request
  dbe_cfg_type cfg_i;         // Link configuration
  logic [7:0]  event_live_i;  // Live conditions
  logic [7:0]  latch_sel_i;   // Latch selects
  logic [7:0]  rd_data_o;     // Read data
  logic [7:0]  status_o;      // Status image
  logic [7:0]  check_flags_o; // Check flags
  logic        irq_n_o;       // Interrupt, active low
  int          err_count;     // Mismatches
  int          comparisons;   // Compares made
  logic [7:0]  rd_val;        // Last read value

  dbe_event_status dut (
    .clock_i       (clock_i),
    .arst_n_i      (arst_n_i),
    .req_i         (req_i),
    .cfg_i         (cfg_i),
    .event_live_i  (event_live_i),
    .latch_sel_i   (latch_sel_i),
    .rd_data_o     (rd_data_o),
    .status_o      (status_o),
    .check_flags_o (check_flags_o),
    .irq_n_o       (irq_n_o)
  );

  // Clock, 5 ns period
  always #2.5 clock_i = ~clock_i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count, four-state exact
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write, taken at the second edge
  task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_i <= {1'b1, 1'b0, a, d};
    @(posedge clock_i);
    req_i <= '0;
  endtask

  // Register read, data sampled one edge after it is taken
  task automatic reg_read(input logic [9:0] a);
    @(posedge clock_i);
    req_i <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    req_i <= '0;
    @(posedge clock_i);
    #1 rd_val = rd_data_o;
  endtask

  // Build a configuration from its fields
  function automatic dbe_cfg_type cfg_of(input logic [7:0] k, input logic [7:0] dly,
      input logic [2:0] sub, input logic [3:0] itp, input logic [2:0] win,
      input logic [3:0] m, input logic [3:0] l, input logic [3:0] s, input logic [3:0] f);
    return '{k, dly, sub, itp, win, m, l, s, f};
  endfunction

  // Apply a configuration and compare the flags
  task automatic chk_cfg(input dbe_cfg_type c, input logic [7:0] exp);
    @(posedge clock_i);
    cfg_i <= c;
    repeat (2) @(posedge clock_i);
    #1 check8(check_flags_o, exp);
  endtask

  // Pulse live conditions for one cycle, then wait past the irq lag
  task automatic pulse_live(input logic [7:0] v);
    @(posedge clock_i);
    event_live_i <= v;
    @(posedge clock_i);
    event_live_i <= 8'h00;
    @(posedge clock_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset image of status, check flags and interrupt
  task automatic t_reset;
    check8(status_o, 8'h00);
    check8(check_flags_o, 8'h00);
    check8({7'h00, irq_n_o}, 8'h01);
  endtask

  // Follow mode: each bit but reserved bit 6 mirrors its live condition, no interrupt
  task automatic t_follow;
    for (int b = 0; b < 8; b++) begin
      @(posedge clock_i);
      event_live_i <= 8'h01 << b;
      @(posedge clock_i);
      #1 check8(status_o, (b == 6) ? 8'h00 : (8'h01 << b));
      check8({7'h00, irq_n_o}, 8'h01);
    end
    @(posedge clock_i);
    event_live_i <= 8'h00;
    @(posedge clock_i);
    #1 check8(status_o, 8'h00);
  endtask

  // Latch mode: rise latches, write one clears, irq tracks the set
  task automatic t_latch;
    @(posedge clock_i);
    latch_sel_i <= 8'hFF;
    pulse_live(8'hA1);
    check8(status_o, 8'hA1);
    check8({7'h00, irq_n_o}, 8'h00);
    reg_write(10'h026, 8'h00);
    repeat (2) @(posedge clock_i);
    #1 check8(status_o, 8'hA1);
    reg_write(10'h026, 8'h01);
    repeat (2) @(posedge clock_i);
    #1 check8(status_o, 8'hA0);
    check8({7'h00, irq_n_o}, 8'h00);
    reg_write(10'h026, 8'hA0);
    repeat (2) @(posedge clock_i);
    #1 check8(status_o, 8'h00);
    check8({7'h00, irq_n_o}, 8'h01);
  endtask

  // Sticky clear drops rotate and trip only; readback paths
  task automatic t_sticky;
    pulse_live(8'h0D);
    check8(status_o, 8'h0D);
    reg_write(10'h03A, 8'h20);
    repeat (3) @(posedge clock_i);
    #1 check8(status_o, 8'h08);
    reg_read(10'h03A);
    check8(rd_val, 8'h20);
    reg_read(10'h026);
    check8(rd_val, 8'h08);
    reg_read(10'h3FF);
    check8(rd_val, 8'h00);
    reg_write(10'h03A, 8'h00);
    reg_write(10'h026, 8'h08);
    repeat (2) @(posedge clock_i);
    #1 check8({irq_n_o, status_o[6:0]}, 8'h80);
  endtask

  // Reset in mid-run drops latched bits and holds flags at zero
  task automatic t_midreset;
    @(posedge clock_i);
    cfg_i <= cfg_of(8'h11, 8'h00, 3'h1, 4'h1, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1);
    pulse_live(8'h02);
    check8({7'h00, irq_n_o}, 8'h00);
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    #1 check8(status_o, 8'h00);
    check8({irq_n_o, check_flags_o[6:0]}, 8'h80);
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    #1 check8({irq_n_o, status_o[6:0]}, 8'h80);
    check8(check_flags_o, 8'h04);
  endtask

  // Configuration checks, each flag driven both set and clear
  task automatic t_checks;
    chk_cfg(cfg_of(8'h10, 8'h10, 3'h1, 4'h1, 3'h3, 4'h2, 4'h4, 4'h1, 4'h1), 8'h00);
    chk_cfg(cfg_of(8'h10, 8'h11, 3'h1, 4'h1, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1), 8'h20);
    chk_cfg(cfg_of(8'h20, 8'h20, 3'h0, 4'h2, 3'h0, 4'h4, 4'h8, 4'h1, 4'h1), 8'h00);
    chk_cfg(cfg_of(8'h10, 8'h00, 3'h1, 4'h1, 3'h4, 4'h2, 4'h4, 4'h1, 4'h1), 8'h10);
    chk_cfg(cfg_of(8'h10, 8'h00, 3'h1, 4'h1, 3'h0, 4'h2, 4'h3, 4'h1, 4'h1), 8'h08);
    chk_cfg(cfg_of(8'h08, 8'h09, 3'h1, 4'h1, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1), 8'h24);
    chk_cfg(cfg_of(8'h11, 8'h00, 3'h1, 4'h1, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1), 8'h04);
    chk_cfg(cfg_of(8'h10, 8'h00, 3'h2, 4'h4, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1), 8'h02);
    chk_cfg(cfg_of(8'h10, 8'h00, 3'h1, 4'h8, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1), 8'h00);
    chk_cfg(cfg_of(8'h10, 8'h00, 3'h1, 4'h0, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1), 8'h01);
    chk_cfg(cfg_of(8'h10, 8'h00, 3'h1, 4'h3, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1), 8'h01);
    reg_write(10'h030, 8'hFF);
    reg_read(10'h030);
    check8(rd_val, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Closing and main sequence
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run of about 120 cycles
  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    clock_i = 1'b0;
    arst_n_i = 1'b0;
    req_i = '0;
    cfg_i = cfg_of(8'h10, 8'h00, 3'h1, 4'h1, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1);
    event_live_i = 8'h00;
    latch_sel_i = 8'h00;
    err_count = 0;
    comparisons = 0;
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    #1 t_reset();
    t_follow();
    t_latch();
    t_sticky();
    t_midreset();
    t_checks();
    complete_run();
  end
endmodule
